// ---- dv/rgb_capture_window_timing_bench.sv ----
// Self-checking bench for the RGB capture window timing block
`timescale 1ns/10ps
`default_nettype none
module rgb_capture_window_timing_bench
  import rgbcap_pkg::*;
  ;

  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [7:0]   awaddr = 8'h00;
  logic         awvalid = 1'b0;
  logic [31:0]  wdata = 32'h0;
  logic [3:0]   wstrb = 4'hf;
  logic         wvalid = 1'b0;
  logic         bready = 1'b1;
  logic [7:0]   araddr = 8'h00;
  logic         arvalid = 1'b0;
  logic         rready = 1'b1;
  logic         pix_ready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, pix_valid;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata;
  rgbcap_pix_s  pix_data;
  rgbcap_pins_s pins;
  logic         stall = 1'b0;
  int           seed = 68533;
  int           seed_r = 68533;
  int           n_mismatch = 0;
  int           compares = 0;
  logic [19:0]  expq [$];
  logic [7:0]   ra [6] = '{8'h4c, 8'h80, 8'h84, 8'h88, 8'h90, 8'h94};
  logic [31:0]  rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0001_0000, 32'h2};

  rgbcap_top rgbcap_top_i (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .awaddr          (awaddr),
    .awvalid         (awvalid),
    .awready         (awready),
    .wdata           (wdata),
    .wstrb           (wstrb),
    .wvalid          (wvalid),
    .wready          (wready),
    .bresp           (bresp),
    .bvalid          (bvalid),
    .bready          (bready),
    .araddr          (araddr),
    .arvalid         (arvalid),
    .arready         (arready),
    .rdata           (rdata),
    .rresp           (rresp),
    .rvalid          (rvalid),
    .rready          (rready),
    .video_hsync_pin (pins.hsync),
    .video_vsync_pin (pins.vsync),
    .video_pixel_pin (pins.rgb),
    .pix_valid       (pix_valid),
    .pix_data        (pix_data),
    .pix_ready       (pix_ready)
  );

  rgbcap_vsrc rgbcap_vsrc_i (
    .aclk (aclk),
    .pins (pins)
  );

  initial
  begin
    forever
      #2.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ready lines are held high, so the answer edge is also the handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1)
      @(posedge aclk);
    check("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    check("rdata", rdata & m, e);
    check("rresp", rresp, er);
  endtask

  // Reserved bits written as ones must read back as zero
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    wr(a, d | ~m, 2'b00);
    rd(a, d, 32'hffff_ffff, 2'b00);
  endtask

  // Pixels inside both windows, first of frame and of line flagged
  function automatic void build(int h0, int hw, int v0, int vh, int nl, int np, int cap);
    logic first;
    first = 1'b1;
    for (int l = 0; l < nl; l++)
      for (int k = 0; k < np; k++)
        if (l >= v0 && l < v0 + vh && k >= h0 && k < h0 + hw && expq.size() < cap)
        begin
          expq.push_back({first, k == h0, l[7:0], k[9:0]});
          first = 1'b0;
        end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    pix_ready <= stall ? 1'b0 : 1'($random(seed_r));
    if (aresetn && pix_valid === 1'b1 && pix_ready)
      check("pixel", pix_data, expq.size() ? expq.pop_front() : 32'hffff_ffff);
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    int   hs, hsz, vs, vsz, mp, ml, nl, np, n;
    logic hpol, vpol, fmt;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[j])
      rd(ra[j], rv[j], 32'hffff_ffff, 2'b00);
    wr(8'hfc, 32'h1234_5678, 2'b10);
    rd(8'hfc, 32'h0, 32'hffff_ffff, 2'b10);
    // Four edge pairs, RGB format off, a FIFO overflow, then VSYNC sampling
    // with the HSYNC count just met and just missed
    for (int i = 0; i < 8; i++)
    begin
      hpol = i[1];
      vpol = i[0];
      fmt = i != 4;
      hs = {$random(seed)} % 10;
      hsz = 1 + {$random(seed)} % 4;
      vs = {$random(seed)} % 3;
      vsz = 1 + {$random(seed)} % 3;
      mp = 1 + {$random(seed)} % 8;
      ml = 1 + {$random(seed)} % 4;
      nl = 5;
      np = 16;
      if (i == 5)
      begin
        hs = 4;
        hsz = 12;
        vs = 1;
        mp = 12;
        nl = 2;
        np = 30;
      end
      wrrd(8'h4c, mp << 16 | ml, 32'h0fff_0fff);
      // Previous frame leaves 1 (after i=5) or 4 (after i=6) HSYNC events
      wrrd(8'h80, i == 6 ? 32'h1 : i == 7 ? 32'h5 : {$random(seed)} & 32'h3fff,
           32'h0000_3fff);
      wrrd(8'h84, hs << 16 | hsz, 32'h0fff_1fff);
      wrrd(8'h88, vs << 16 | vsz, 32'h01ff_1fff);
      wrrd(8'h90, 32'h0001_0000 | (fmt ? {hpol, vpol} : 2'b11), 32'h0001_0003);
      wrrd(8'h94, (fmt ? 32'h3 : 32'h1) | (i > 5 ? 32'h4 : 32'h0), 32'h7);
      stall <= i == 5;
      // A missed frame event leaves lines counting past every window
      build(hs > 4 ? hs - 4 : 0, 2 * (hsz < mp ? hsz : mp), vs > 1 ? vs - 1 : 0,
            vsz < ml ? vsz : ml, nl, np, i == 5 ? 17 : i == 7 ? 0 : 999);
      rgbcap_vsrc_i.send_frame(hpol, vpol, nl, np);
      if (i == 5)
      begin
        rd(8'h98, 32'h1, 32'h1, 2'b00);
        stall <= 1'b0;
      end
      for (n = 0; n < 500 && expq.size() > 0; n++)
        @(posedge aclk);
      check("pixels left", expq.size(), 32'h0);
    end
    wr(8'h98, 32'h1, 2'b00);
    rd(8'h98, 32'h0, 32'h1, 2'b00);
    test_done();
  end

endmodule
`default_nettype wire

// ---- dv/rgbcap_vsrc.sv ----
// Video source model: sync edges and tagged pixel ramps, one pixel per clock
`timescale 1ns/10ps
`default_nettype none
module rgbcap_vsrc
  import rgbcap_pkg::*;
(
  // Clock
  input  wire logic        aclk,
  // Pins toward the capture block
  output var rgbcap_pins_s pins
);

  initial
  begin
    pins = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line -1 is an idle preamble; the VSYNC edge lands with the line 0 HSYNC
  // edge and VSYNC stays active through line 0, so line 0 is counted as 0
  task automatic send_frame(input logic hpol, input logic vpol, input int nl, input int np);
    for (int l = -1; l < nl; l++)
      for (int k = -8; k < np; k++)
      begin
        @(posedge aclk);
        pins.vsync <= (l == 0 && k >= -1) ? vpol : !vpol;
        // HSYNC active three clocks, so a wrong edge shifts pixels by three
        pins.hsync <= (l >= 0 && k >= -1 && k < 2) ? hpol : !hpol;
        // Blanking alternates inverted data and the stale last pixel each clock
        pins.rgb   <= (l >= 0 && k >= 0) ? {l[7:0], k[9:0]} : ~pins.rgb;
      end
  endtask

endmodule
`default_nettype wire

// ---- logic/rgbcap_fifo.sv ----
// Pixel FIFO with a registered output stage
`timescale 1ns/10ps
`default_nettype none
module rgbcap_fifo
  import rgbcap_pkg::*;
#(
  parameter int W     = 20,
  parameter int DEPTH = 16
)(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Fill side
  input  wire logic         s_valid,
  input  wire logic [W-1:0] s_data,
  output logic              s_ready,
  // Drain side
  output logic              m_valid,
  output logic [W-1:0]      m_data,
  input  wire logic         m_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  assign s_ready = (cnt != (AW+1)'(DEPTH));
  assign push    = s_valid && s_ready;
  assign pop     = (cnt != '0) && (!m_valid || m_ready);

  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wp] <= s_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'h1;
      if (pop)
        rp <= rp + 1'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt <= '0;
    else if (push && !pop)
      cnt <= cnt + 1'h1;
    else if (!push && pop)
      cnt <= cnt - 1'h1;
  end

  // Output register keeps the top-level output straight from a flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      m_valid <= 1'h0;
      m_data  <= '0;
    end
    else if (pop)
    begin
      m_valid <= 1'h1;
      m_data  <= mem[rp];
    end
    else if (m_ready)
      m_valid <= 1'h0;
  end

endmodule
`default_nettype wire

// ---- logic/rgbcap_map.svh ----
// Register offsets, field positions, masks and reset values of the RGB capture block
`ifndef RGBCAP_MAP_SVH
`define RGBCAP_MAP_SVH

`define RC_MAG_OFS        8'h4c
`define RC_HC_OFS         8'h80
`define RC_HWIN_OFS       8'h84
`define RC_VWIN_OFS       8'h88
`define RC_SYNC_OFS       8'h90
`define RC_CTRL_OFS       8'h94
`define RC_STAT_OFS       8'h98

`define RC_MAG_MASK       32'h0fff_0fff
`define RC_HC_MASK        32'h0000_3fff
`define RC_HWIN_MASK      32'h0fff_1fff
`define RC_VWIN_MASK      32'h01ff_1fff
`define RC_SYNC_MASK      32'h0001_0003
`define RC_CTRL_MASK      32'h0000_0007

`define RC_CFG_RST        32'h0000_0000
`define RC_SYNC_RST       32'h0001_0000
`define RC_CTRL_RST       32'h0000_0002

`define RC_VPOL_BIT       0
`define RC_HPOL_BIT       1
`define RC_KIND_BIT       16
`define RC_EN_BIT         0
`define RC_FMT_BIT        1
`define RC_VSAMP_BIT      2
`define RC_OVF_BIT        0

`define RC_HSTART_BIAS    12'h004
`define RC_VSTART_BIAS    9'h001
`define RC_LINE_BUF_PIX   840

`endif

// ---- logic/rgbcap_pkg.sv ----
// Types shared by the RGB capture block
`default_nettype none
package rgbcap_pkg;

  typedef enum logic [1:0] {
    RC_OKAY   = 2'b00,
    RC_SLVERR = 2'b10
  } rgbcap_resp_e;

  typedef struct packed {
    logic        sof;
    logic        sol;
    logic [17:0] rgb;
  } rgbcap_pix_s;

  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic [17:0] rgb;
  } rgbcap_pins_s;

endpackage
`default_nettype wire

// ---- logic/rgbcap_top.sv ----
// RGB capture window timing: register file, sync edge logic, windows, FIFO
//
// Operation
// - Magnified output line count comes from bits 11-0 of the magnify size.
// - Magnified output width comes from bits 27-16, in pairs of pixels.
// - HSYNC cycle count is a 14-bit field, actual count is value plus one.
// - HSYNC cycle count matters only when VSYNC is sampled.
// - Horizontal window size is bits 12-0, in pairs of pixels.
// - Horizontal window starts at start field bits 27-16 minus four.
// - Valid line count comes from bits 12-0 of the vertical window.
// - First valid line is vertical start field bits 24-16 minus one.
// - Sync bit 0 picks the VSYNC edge, resets to zero.
// - Sync bit 1 picks the HSYNC edge, resets to zero.
// - Sync bit 16 selects direct RGB input, resets to one; zero reserved.
// - Edge selection applies only in RGB input format.
// - With input kind bit one, pixels are direct RGB666 data.
`timescale 1ns/10ps
`default_nettype none
`include "rgbcap_map.svh"
module rgbcap_top
  import rgbcap_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  // AXI4-Lite read
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  // Video input pins
  input  wire logic         video_hsync_pin,
  input  wire logic         video_vsync_pin,
  input  wire logic [17:0]  video_pixel_pin,
  // Captured pixel stream
  output logic              pix_valid,
  output var rgbcap_pix_s   pix_data,
  input  wire logic         pix_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] magnify_display_size;
  logic [31:0] rgb_hsync_cycle_count;
  logic [31:0] rgb_horizontal_window;
  logic [31:0] rgb_vertical_window;
  logic [31:0] rgb_sync_control;
  logic [31:0] capture_control;
  logic        overflow;

  logic [11:0] magnify_out_lines;
  logic [11:0] magnify_out_pixel_pairs;
  logic [13:0] hsync_cycles;
  logic [12:0] horizontal_window_size;
  logic [11:0] horizontal_window_start;
  logic [12:0] vertical_window_size;
  logic [8:0]  vertical_window_start;
  logic        vsync_edge_polarity;
  logic        hsync_edge_polarity;
  logic        rgb_input_kind_select;
  logic        cap_enable;
  logic        fmt_rgb;
  logic        vsync_sample;

  assign magnify_out_lines       = magnify_display_size[11:0];
  assign magnify_out_pixel_pairs = magnify_display_size[27:16];
  assign hsync_cycles            = rgb_hsync_cycle_count[13:0];
  assign horizontal_window_size  = rgb_horizontal_window[12:0];
  assign horizontal_window_start = rgb_horizontal_window[27:16];
  assign vertical_window_size    = rgb_vertical_window[12:0];
  assign vertical_window_start   = rgb_vertical_window[24:16];
  assign vsync_edge_polarity     = rgb_sync_control[`RC_VPOL_BIT];
  assign hsync_edge_polarity     = rgb_sync_control[`RC_HPOL_BIT];
  assign rgb_input_kind_select   = rgb_sync_control[`RC_KIND_BIT];
  assign cap_enable              = capture_control[`RC_EN_BIT];
  assign fmt_rgb                 = capture_control[`RC_FMT_BIT];
  assign vsync_sample            = capture_control[`RC_VSAMP_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_held;
  logic        w_held;
  logic        do_write;
  logic        next_aw_held;
  logic        next_w_held;
  logic        next_bvalid;
  logic        next_rvalid;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic        ovf_clear;
  logic [12:0] line_cnt;

  assign do_write = aw_held && w_held && !bvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    if (awvalid && awready)
      next_aw_held = 1'h1;
    if (wvalid && wready)
      next_w_held = 1'h1;
    if (do_write)
    begin
      next_aw_held = 1'h0;
      next_w_held  = 1'h0;
    end
    next_bvalid = do_write || (bvalid && !bready);
    next_rvalid = (arvalid && arready) || (rvalid && !rready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'h0;
      w_held  <= 1'h0;
      awready <= 1'h0;
      wready  <= 1'h0;
      bvalid  <= 1'h0;
      arready <= 1'h0;
      rvalid  <= 1'h0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      bvalid  <= next_bvalid;
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end
    else
    begin
      if (awvalid && awready)
        aw_addr_q <= {awaddr[7:2], 2'h0};
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  always_comb
  begin
    case (aw_addr_q)
      `RC_MAG_OFS, `RC_HC_OFS, `RC_HWIN_OFS, `RC_VWIN_OFS,
      `RC_SYNC_OFS, `RC_CTRL_OFS, `RC_STAT_OFS: wr_hit = 1'h1;
      default:                                  wr_hit = 1'h0;
    endcase
  end

  always_comb
  begin
    rd_hit = 1'h1;
    case ({araddr[7:2], 2'h0})
      `RC_MAG_OFS:  rd_word = magnify_display_size;
      `RC_HC_OFS:   rd_word = rgb_hsync_cycle_count;
      `RC_HWIN_OFS: rd_word = rgb_horizontal_window;
      `RC_VWIN_OFS: rd_word = rgb_vertical_window;
      `RC_SYNC_OFS: rd_word = rgb_sync_control;
      `RC_CTRL_OFS: rd_word = capture_control;
      `RC_STAT_OFS: rd_word = {3'h0, line_cnt, 15'h0, overflow};
      default:
      begin
        rd_word = '0;
        rd_hit  = 1'h0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bresp <= RC_OKAY;
      rresp <= RC_OKAY;
      rdata <= '0;
    end
    else
    begin
      if (do_write)
        bresp <= wr_hit ? RC_OKAY : RC_SLVERR;
      if (arvalid && arready)
      begin
        rresp <= rd_hit ? RC_OKAY : RC_SLVERR;
        rdata <= rd_word;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      magnify_display_size  <= `RC_CFG_RST;
      rgb_hsync_cycle_count <= `RC_CFG_RST;
      rgb_horizontal_window <= `RC_CFG_RST;
      rgb_vertical_window   <= `RC_CFG_RST;
      rgb_sync_control      <= `RC_SYNC_RST;
      capture_control       <= `RC_CTRL_RST;
    end
    else if (do_write)
    begin
      case (aw_addr_q)
        `RC_MAG_OFS:
          magnify_display_size <= merge(magnify_display_size, w_data_q, w_strb_q,
                                        `RC_MAG_MASK);
        `RC_HC_OFS:
          rgb_hsync_cycle_count <= merge(rgb_hsync_cycle_count, w_data_q, w_strb_q,
                                         `RC_HC_MASK);
        `RC_HWIN_OFS:
          rgb_horizontal_window <= merge(rgb_horizontal_window, w_data_q, w_strb_q,
                                         `RC_HWIN_MASK);
        `RC_VWIN_OFS:
          rgb_vertical_window <= merge(rgb_vertical_window, w_data_q, w_strb_q,
                                       `RC_VWIN_MASK);
        `RC_SYNC_OFS:
          rgb_sync_control <= merge(rgb_sync_control, w_data_q, w_strb_q,
                                    `RC_SYNC_MASK);
        `RC_CTRL_OFS:
          capture_control <= merge(capture_control, w_data_q, w_strb_q,
                                   `RC_CTRL_MASK);
        default:
          capture_control <= capture_control;
      endcase
    end
  end

  assign ovf_clear = do_write && (aw_addr_q == `RC_STAT_OFS) && w_strb_q[0]
                     && w_data_q[`RC_OVF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and sync edges
  rgbcap_pins_s pin_s1;
  rgbcap_pins_s pin_s2;
  logic         hs_d;
  logic         vs_d;
  logic         h_evt;
  logic         v_evt;
  logic         f_evt;
  logic         v_active;
  logic [13:0]  hcount;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      hs_d   <= 1'h0;
      vs_d   <= 1'h0;
    end
    else
    begin
      pin_s1 <= '{hsync: video_hsync_pin, vsync: video_vsync_pin, rgb: video_pixel_pin};
      pin_s2 <= pin_s1;
      hs_d   <= pin_s2.hsync;
      vs_d   <= pin_s2.vsync;
    end
  end

  // Outside RGB format the polarity bits are ignored and falling edges are used
  always_comb
  begin
    if (fmt_rgb && hsync_edge_polarity)
      h_evt = pin_s2.hsync && !hs_d;
    else
      h_evt = !pin_s2.hsync && hs_d;
    if (fmt_rgb && vsync_edge_polarity)
    begin
      v_evt    = pin_s2.vsync && !vs_d;
      v_active = pin_s2.vsync;
    end
    else
    begin
      v_evt    = !pin_s2.vsync && vs_d;
      v_active = !pin_s2.vsync;
    end
  end

  // Sampling mode: VSYNC level looked at on HSYNC, after hsync_cycles+1 lines
  assign f_evt = vsync_sample ? (h_evt && v_active && hcount >= hsync_cycles)
                              : v_evt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hcount <= '0;
    else if (f_evt)
      hcount <= '0;
    else if (h_evt && hcount != '1)
      hcount <= hcount + 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel and line counters, windows
  logic [12:0] pix_cnt;
  logic        frame_ok;
  logic        sof_pend;
  logic        sol_pend;
  logic [14:0] h_lo;
  logic [14:0] h_hi;
  logic [14:0] h_cap;
  logic [14:0] v_lo;
  logic [14:0] v_hi;
  logic [14:0] v_cap;
  logic        in_win;
  logic        take;
  logic        fifo_ready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pix_cnt  <= '0;
      line_cnt <= '0;
    end
    else
    begin
      if (h_evt || f_evt)
        pix_cnt <= '0;
      else if (pix_cnt != '1)
        pix_cnt <= pix_cnt + 1'h1;
      if (f_evt)
        line_cnt <= '0;
      else if (h_evt && line_cnt != '1)
        line_cnt <= line_cnt + 1'h1;
    end
  end

  // Start fields below their bias clamp to zero rather than wrap
  always_comb
  begin
    h_lo  = (horizontal_window_start >= `RC_HSTART_BIAS) ?
            15'(horizontal_window_start - `RC_HSTART_BIAS) : '0;
    h_hi  = h_lo + 15'({horizontal_window_size, 1'h0});
    h_cap = h_lo + 15'({magnify_out_pixel_pairs, 1'h0});
    v_lo  = (vertical_window_start >= `RC_VSTART_BIAS) ?
            15'(vertical_window_start - `RC_VSTART_BIAS) : '0;
    v_hi  = v_lo + 15'(vertical_window_size);
    v_cap = v_lo + 15'(magnify_out_lines);
    in_win = (15'(pix_cnt) >= h_lo) && (15'(pix_cnt) < h_hi) && (15'(pix_cnt) < h_cap)
          && (15'(line_cnt) >= v_lo) && (15'(line_cnt) < v_hi)
          && (15'(line_cnt) < v_cap);
  end

  // Kind bit zero is reserved; nothing is forwarded then
  assign take = cap_enable && rgb_input_kind_select && frame_ok && in_win;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_ok <= 1'h0;
      sof_pend <= 1'h0;
      sol_pend <= 1'h0;
    end
    else
    begin
      if (f_evt)
        frame_ok <= 1'h1;
      if (f_evt)
        sof_pend <= 1'h1;
      else if (take && fifo_ready)
        sof_pend <= 1'h0;
      if (h_evt || f_evt)
        sol_pend <= 1'h1;
      else if (take && fifo_ready)
        sol_pend <= 1'h0;
    end
  end

  // A video source cannot stall: a full FIFO drops the pixel and flags it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overflow <= 1'h0;
    else if (take && !fifo_ready)
      overflow <= 1'h1;
    else if (ovf_clear)
      overflow <= 1'h0;
  end

  rgbcap_fifo #(
    .W     ($bits(rgbcap_pix_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s_valid (take),
    .s_data  ({sof_pend, sol_pend, pin_s2.rgb}),
    .s_ready (fifo_ready),
    .m_valid (pix_valid),
    .m_data  (pix_data),
    .m_ready (pix_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hrise_sel;
    fmt_rgb && hsync_edge_polarity && pin_s2.hsync && !hs_d;
  endsequence

  sequence s_vfall_plain;
    !fmt_rgb && !vsync_sample && !pin_s2.vsync && vs_d;
  endsequence

  chk_hwin_size:
  assert property (take |-> 15'(pix_cnt) + 15'(`RC_HSTART_BIAS)
                   < 15'(horizontal_window_start) + 15'({horizontal_window_size, 1'h0})
                   || horizontal_window_start < `RC_HSTART_BIAS)
    else $error("pixel taken past horizontal window end");

  chk_hwin_start:
  assert property (take |-> 15'(pix_cnt) + 15'(`RC_HSTART_BIAS) >= 15'(horizontal_window_start))
    else $error("pixel taken before horizontal window start");

  chk_vwin_start:
  assert property (take |-> 15'(line_cnt) + 15'(`RC_VSTART_BIAS) >= 15'(vertical_window_start))
    else $error("pixel taken before first valid line");

  chk_vwin_size:
  assert property (take && vertical_window_start != '0 |->
                   15'(line_cnt) + 15'(`RC_VSTART_BIAS)
                   < 15'(vertical_window_start) + 15'(vertical_window_size))
    else $error("pixel taken past last valid line");

  chk_mag_lines:
  assert property (take && vertical_window_start != '0 |->
                   15'(line_cnt) + 15'(`RC_VSTART_BIAS)
                   < 15'(vertical_window_start) + 15'(magnify_out_lines))
    else $error("pixel taken past magnify line count");

  chk_hedge_rise:
  assert property (s_hrise_sel |=> pix_cnt == '0 ##1 pix_cnt == 13'h0001)
    else $error("selected hsync edge did not restart pixel count");

  chk_vedge_plain:
  assert property (s_vfall_plain |=> line_cnt == '0 && pix_cnt == '0)
    else $error("vsync falling edge outside rgb format ignored");

  chk_vsample_gate:
  assert property (vsync_sample && h_evt && hcount < hsync_cycles && line_cnt != '1
                   |=> line_cnt == $past(line_cnt) + 13'h1)
    else $error("frame restarted before hsync count reached");

  chk_kind_gate:
  assert property (take |-> rgb_input_kind_select && cap_enable)
    else $error("pixel taken without direct rgb input mode");

  chk_sync_reset:
  assert property (@(posedge aclk) disable iff (1'h0)
                   !aresetn |=> rgb_sync_control == `RC_SYNC_RST)
    else $error("sync control reset value wrong");

  chk_bresp_hold:
  assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before acceptance");

endmodule
`default_nettype wire
